// File: twl_pkg.sv
package twl_pkg;

  // ------------------------------------------------------------
  // word layout
  // ------------------------------------------------------------
  localparam int unsigned WORD_W    = 32;
  localparam int unsigned SEL_W     = 3;
  localparam int unsigned SEL_LSB   = 0;
  localparam int unsigned NUM_REGS  = 6;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // ------------------------------------------------------------
  // power-down bit positions within selected words
  // ------------------------------------------------------------
  localparam logic [2:0]  PD_REG_SEL = 3'h2;
  localparam int unsigned PD_BIT_POS = 5;
  localparam int unsigned PUMP_3ST_POS = 4;

  // ------------------------------------------------------------
  // pin timing and the counts derived from it
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned LOAD_PULSE_NS = 20;
  localparam int unsigned LOAD_PULSE_CYC =
    (LOAD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic serial_clk;
    logic serial_data;
    logic load_strobe;
    logic chip_enable;
  } twl_pins_t;

  typedef struct packed {
    logic powered;
    logic pump_tristate;
  } twl_power_t;

endpackage

// File: twl_sync.sv
`timescale 1ns/10ps
`default_nettype none
module twl_sync
  import twl_pkg::*;
#(
  parameter int unsigned W = 4
) (
  input  wire logic         clock,    // system clock
  input  wire logic         sys_rst,  // synchronous reset
  input  wire logic [W-1:0] async_in, // pins from outside
  output logic      [W-1:0] level,    // filtered level
  output logic      [W-1:0] rise      // one-cycle rising pulse
);

  // ------------------------------------------------------------
  // three stages; a change counts once stages two and three agree
  // ------------------------------------------------------------
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] level_q;

  wire  [W-1:0] agree = ~(s2_q ^ s3_q);
  wire  [W-1:0] level_d = (agree & s2_q) | (~agree & level_q);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      level_q <= '0;
    end else begin
      s1_q    <= async_in;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= level_d;
    end
  end

  assign level = level_q;
  assign rise  = level_d & ~level_q;

endmodule
`default_nettype wire

// File: twl_port.sv
`timescale 1ns/10ps
`default_nettype none
// Operation
// R01 - shift data on each serial clock rise
// R02 - words arrive msb first
// R03 - low three bits select target register
// R04 - strobe rise loads word into selected register
// R05 - chip enable low: powered down, pump tristated
// R06 - chip enable high: power-down bits still apply
// R07 - host keeps strobe low during shifting
module twl_port
  import twl_pkg::*;
#(
  parameter int unsigned WIDTH = WORD_W,
  parameter int unsigned REGS  = NUM_REGS
) (
  input  wire logic             clock,          // 10 MHz system clock
  input  wire logic             sys_rst,        // synchronous reset, high
  input  wire twl_pins_t        pins,           // raw serial pins
  output logic [WIDTH-1:0]      reg_word [REGS], // loaded registers
  output logic [REGS-1:0]       reg_loaded,     // one-cycle load pulse per register
  output logic [WIDTH-1:0]      shift_word,     // current shift register
  output logic                  powered,        // device powered up
  output logic                  pump_output,    // pump drive level (idle low)
  output logic                  pump_output_oe  // pump driven, low is high-z
);

  // ------------------------------------------------------------
  // pin synchronisation
  // ------------------------------------------------------------
  logic [3:0] lvl;
  logic [3:0] rise;

  twl_sync #(.W(4)) u_sync (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .async_in ({pins.serial_clk, pins.serial_data, pins.load_strobe, pins.chip_enable}),
    .level    (lvl),
    .rise     (rise)
  );

  wire sclk_rise = rise[3];
  wire sdata     = lvl[2];
  wire load_rise = rise[1];
  wire chip_en   = lvl[0];

  // ------------------------------------------------------------
  // shift register
  // ------------------------------------------------------------
  logic [WIDTH-1:0] shift_q;
  // clock rise is taken from level_d, one cycle ahead of the filtered data level, so data must settle a cycle before the clock rises
  wire  [WIDTH-1:0] shift_d = {shift_q[WIDTH-2:0], sdata}; // see R01 see R02

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      shift_q <= '0;
    end else if (sclk_rise) begin
      shift_q <= shift_d; // see R01
    end
  end

  // ------------------------------------------------------------
  // register select and load
  // ------------------------------------------------------------
  // the strobe edge is not gated against clock edges; the host must finish
  // the word first, or a half-shifted word is loaded
  wire [SEL_W-1:0] sel = shift_q[SEL_LSB +: SEL_W]; // see R03
  wire             sel_ok = (32'(sel) < REGS);
  wire             do_load = load_rise & sel_ok; // see R04 see R07

  logic [WIDTH-1:0] regs_q [REGS];
  logic [REGS-1:0]  loaded_q;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < REGS; i++) begin
        regs_q[i] <= WIDTH'(REG_RESET);
      end
      loaded_q <= '0;
    end else begin
      for (int i = 0; i < REGS; i++) begin
        loaded_q[i] <= do_load && (32'(sel) == i);
        if (do_load && (32'(sel) == i)) begin
          regs_q[i] <= shift_q; // see R04
        end
      end
    end
  end

  // ------------------------------------------------------------
  // power control
  // ------------------------------------------------------------
  twl_power_t pwr_q;
  wire soft_pd   = regs_q[PD_REG_SEL][PD_BIT_POS];
  wire soft_3st  = regs_q[PD_REG_SEL][PUMP_3ST_POS];
  wire powered_d = chip_en & ~soft_pd; // see R05 see R06
  wire pump_3st_d = ~chip_en | soft_pd | soft_3st; // see R05 see R06

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pwr_q <= '{powered: 1'b0, pump_tristate: 1'b1};
    end else begin
      pwr_q.powered       <= powered_d;
      pwr_q.pump_tristate <= pump_3st_d;
    end
  end

  assign reg_word       = regs_q;
  assign reg_loaded     = loaded_q;
  assign shift_word     = shift_q;
  assign powered        = pwr_q.powered;
  assign pump_output    = 1'b0;
  assign pump_output_oe = ~pwr_q.pump_tristate; // see R05

endmodule
`default_nettype wire

// File: twl_port_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module twl_port_monitor
  import twl_pkg::*;
#(parameter int unsigned WIDTH = 32, parameter int unsigned REGS = 6) (
  input wire logic             clock,         // clock
  input wire logic             sys_rst,       // reset
  input wire twl_pins_t        pins,          // pins
  input wire logic [WIDTH-1:0] reg_word[REGS],// regs
  input wire logic [REGS-1:0]  reg_loaded,    // pulses
  input wire logic [WIDTH-1:0] shift_word,    // shifter
  input wire logic             powered,       // power
  input wire logic             pump_output_oe // pump
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire logic [2:0] sel = shift_word[2:0];
  a_shift_in: assert property ($rose(pins.serial_clk) |->
    ##[3:5] shift_word[0] == pins.serial_data) else $error("bit lost");
  a_msb_first: assert property (!$past(sys_rst) && $changed(shift_word) |->
    shift_word[WIDTH-1:1] == $past(shift_word[WIDTH-2:0])) else $error("bad shift");
  a_sel_load: assert property ($rose(pins.load_strobe) && sel < REGS |->
    ##[2:5] reg_loaded[sel] && reg_word[sel] == shift_word) else $error("no load");
  a_bad_sel: assert property ($rose(pins.load_strobe) && sel >= REGS |->
    ##1 (reg_loaded == '0)[*6]) else $error("stray load");
  a_one_load: assert property ($onehot0(reg_loaded)) else $error("two loads");
  a_ce_low: assert property (!pins.chip_enable[*8] |->
    !powered && !pump_output_oe) else $error("not down");
  a_ce_high: assert property ((pins.chip_enable && $stable(reg_word[PD_REG_SEL]))[*8] |->
    powered == !reg_word[PD_REG_SEL][PD_BIT_POS]) else $error("bad power");
  c_load: cover property (reg_loaded[2]);
  c_bad: cover property ($rose(pins.load_strobe) && sel == 3'h7);
  c_down: cover property ($fell(powered));
endmodule
`default_nettype wire

// File: twl_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module twl_host_model
  import twl_pkg::*;
(
  input  wire logic     clock, // pacing clock
  output var twl_pins_t pins   // host pins
);
  initial begin
    pins = '0;
    pins.chip_enable = 1'b1;
  end
  // link clock stands low between words
  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      repeat (2) @(negedge clock);
      pins.serial_data = w[i];
      repeat (2) @(negedge clock);
      pins.serial_clk = 1'b1;
      repeat (4) @(negedge clock);
      pins.serial_clk = 1'b0;
    end
    repeat (2) @(negedge clock);
    pins.serial_data = ~w[0]; // released, stale bit must not pass as valid
    repeat (2) @(negedge clock);
    pins.load_strobe = 1'b1;
    repeat (4) @(negedge clock);
    pins.load_strobe = 1'b0;
  endtask
  task automatic set_ce(input logic v);
    @(negedge clock);
    pins.chip_enable = v;
  endtask
endmodule
`default_nettype wire

// File: test_three_wire_register_load_port.sv
`timescale 1ns/10ps
`default_nettype none
module test_three_wire_register_load_port;
  import twl_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  twl_pins_t pins;
  logic [31:0] rw[6], exp_q[6], sw;
  logic pw, oe;
  int num_errors = 0, n_compared = 0, cyc = 0;
  always #50 clock = ~clock;
  twl_host_model host (.clock(clock), .pins(pins));
  twl_port uut (.clock(clock), .sys_rst(sys_rst), .pins(pins), .reg_word(rw), .reg_loaded(),
    .shift_word(sw), .powered(pw), .pump_output(), .pump_output_oe(oe));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("errors=%0d compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_loads;
    logic [31:0] w;
    for (int s = 0; s < 8; s++) begin
      w = 32'h9e37_79c0 | (32'(s) << 8) | 32'(s);
      host.send(w);
      repeat (8) @(negedge clock);
      if (s < 6) exp_q[s] = w;
      chk(sw, w);
      for (int k = 0; k < 6; k++) chk(rw[k], exp_q[k]);
    end
    $display("loads done");
  endtask
  task automatic t_power;
    host.set_ce(1'b0);
    repeat (10) @(negedge clock);
    chk({30'h0, pw, oe}, 32'h0);
    host.set_ce(1'b1);
    repeat (10) @(negedge clock);
    chk({30'h0, pw, oe}, 32'h3);
    host.send(32'h0000_0022);
    repeat (10) @(negedge clock);
    chk({30'h0, pw, oe}, 32'h0);
    host.send(32'h0000_0002);
    repeat (10) @(negedge clock);
    chk({30'h0, pw, oe}, 32'h3);
    $display("power done");
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    foreach (exp_q[k]) exp_q[k] = REG_RESET;
    repeat (16) @(negedge clock);
    sys_rst = 1'b0;
    repeat (8) @(negedge clock);
    t_loads();
    t_power();
    wrap_up();
  end
endmodule
bind twl_port twl_port_monitor #(.WIDTH(WIDTH), .REGS(REGS)) mon (.clock(clock),
  .sys_rst(sys_rst), .pins(pins), .reg_word(reg_word), .reg_loaded(reg_loaded),
  .shift_word(shift_word), .powered(powered), .pump_output_oe(pump_output_oe));
`default_nettype wire
